// ### design/ufs_pkg.sv
package ufs_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] UFS_OFS_STATUS = 8'h00;
    localparam logic [7:0] UFS_OFS_SERCTL = 8'h04;
    localparam logic [7:0] UFS_OFS_FIFOCTL = 8'h08;
    localparam logic [7:0] UFS_OFS_TXDATA = 8'h0C;
    localparam logic [7:0] UFS_OFS_RXDATA = 8'h10;
    localparam logic [7:0] UFS_OFS_COUNT = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int UFS_BIT_ER = 7;
    localparam int UFS_BIT_TRANSMIT_END_FLAG = 6;
    localparam int UFS_BIT_TRANSMIT_FIFO_LOW_FLAG = 5;
    localparam int UFS_BIT_BRK = 4;
    localparam int UFS_BIT_FER = 3;
    localparam int UFS_BIT_PER = 2;
    localparam int UFS_BIT_RDF = 1;
    localparam int UFS_BIT_DR = 0;
    localparam logic [15:0] UFS_STATUS_RESET = 16'h0060;
    localparam logic [7:0] UFS_CLEARABLE = 8'hF3;
    localparam int UFS_SC_TE = 5;
    localparam int UFS_SC_RE = 4;
    localparam int UFS_SC_PAR_EN = 1;
    localparam int UFS_SC_PAR_ODD = 0;
    localparam int UFS_FC_RTRG_HI = 7;
    localparam int UFS_FC_RTRG_LO = 6;
    localparam int UFS_FC_TTRG_HI = 5;
    localparam int UFS_FC_TTRG_LO = 4;
    localparam int UFS_FC_TX_FLUSH = 2;
    localparam int UFS_FC_RX_FLUSH = 1;
    localparam logic [7:0] UFS_SERCTL_RESET = 8'h00;
    localparam logic [7:0] UFS_FIFOCTL_RESET = 8'h00;
    localparam int UFS_FIFO_DEPTH = 16;
    localparam int UFS_CNT_W = 5;
    localparam int UFS_RXW = 10;
    localparam int UFS_RX_FER = 9;
    localparam int UFS_RX_PER = 8;

    // ****************************************
    // Trigger level tables
    // ****************************************
    localparam logic [4:0] UFS_TTRG_0 = 5'h08;
    localparam logic [4:0] UFS_TTRG_1 = 5'h04;
    localparam logic [4:0] UFS_TTRG_2 = 5'h02;
    localparam logic [4:0] UFS_TTRG_3 = 5'h01;
    localparam logic [4:0] UFS_RTRG_0 = 5'h01;
    localparam logic [4:0] UFS_RTRG_1 = 5'h04;
    localparam logic [4:0] UFS_RTRG_2 = 5'h08;
    localparam logic [4:0] UFS_RTRG_3 = 5'h0E;

    // Two-bit select to transmit trigger level
    function automatic logic [4:0] ufs_tx_trig(input logic [1:0] sel);
        case (sel)
            2'h0: ufs_tx_trig = UFS_TTRG_0;
            2'h1: ufs_tx_trig = UFS_TTRG_1;
            2'h2: ufs_tx_trig = UFS_TTRG_2;
            default: ufs_tx_trig = UFS_TTRG_3;
        endcase
    endfunction

    // Two-bit select to receive trigger level
    function automatic logic [4:0] ufs_rx_trig(input logic [1:0] sel);
        case (sel)
            2'h0: ufs_rx_trig = UFS_RTRG_0;
            2'h1: ufs_rx_trig = UFS_RTRG_1;
            2'h2: ufs_rx_trig = UFS_RTRG_2;
            default: ufs_rx_trig = UFS_RTRG_3;
        endcase
    endfunction
endpackage

// ### design/ufs_fifo.sv
`timescale 1ns/10ps
module ufs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CNT_W = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    output logic [WIDTH-1:0] headData,
    output logic [CNT_W-1:0] count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] ONE_A = AW'(1);
    localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic doPush;
    logic doPop;

    // Push into a full FIFO is dropped so stored entries stay intact
    assign doPush = push && !full;
    assign doPop = pop && !empty;
    assign full = (count == DEPTH_C);
    assign empty = (count == '0);
    assign headData = mem[rdPtr];

    // Storage array, no reset needed on data
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= pushData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + ONE_A;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + ONE_A;
            end
            if (doPush && !doPop) begin
                count <= count + ONE_C;
            end else if (doPop && !doPush) begin
                count <= count - ONE_C;
            end
        end
    end
endmodule

// ### design/ufs_status.sv
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module ufs_status
    import ufs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Power state, same clock domain
    input wire logic standby,
    input wire logic moduleStandby,
    // Receive shifter events
    input wire logic rxCharDone,
    input wire logic [7:0] rxData,
    input wire logic rxParityBit,
    input wire logic rxStopBit,
    input wire logic rxBreak,
    input wire logic rxDataReady,
    // Transmit shifter handshake
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txTake,
    input wire logic txLastBitDone
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] flags;
    logic [7:0] armed;
    logic [7:0] serialControl;
    logic [7:0] fifoControl;
    logic [7:0] errCount;
    logic charFramingError;
    logic charParityError;
    logic [7:0] next_flags;
    logic [7:0] setEv;
    logic [7:0] clrEv;
    logic [15:0] statusWord;
    logic standbyAny;
    logic access;
    logic busWr;
    logic busRd;
    logic txPush;
    logic txPop;
    logic rxPush;
    logic rxPop;
    logic [7:0] txHead;
    logic [UFS_RXW-1:0] rxHead;
    logic [UFS_RXW-1:0] rxEntry;
    logic [UFS_CNT_W-1:0] txCount;
    logic [UFS_CNT_W-1:0] rxCount;
    logic [UFS_CNT_W-1:0] txCountAfter;
    logic [UFS_CNT_W-1:0] rxCountAfter;
    logic [4:0] txTrig;
    logic [4:0] rxTrig;
    logic txFull;
    logic txEmpty;
    logic rxFull;
    logic rxEmpty;
    logic frameErr;
    logic parityErr;
    logic rxErr;
    logic headErr;

    // ****************************************
    // Bus decode
    // ****************************************
    // Every access is answered one cycle after it is seen
    assign access = (read || write) && waitrequest;
    assign busWr = access && write;
    assign busRd = access && read;
    assign standbyAny = standby || moduleStandby;

    // Register side effects of the access
    assign txPush = busWr && byteenable[0] && (address == UFS_OFS_TXDATA);
    assign rxPop = busRd && (address == UFS_OFS_RXDATA) && !rxEmpty;
    assign txPop = txTake && !txEmpty;

    // Accepted as a pulse; wait state raised again after the answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !access;
        end
    end

    // ****************************************
    // Receive character check
    // ****************************************
    // Only the first stop bit is offered by the shifter, the second is never looked at
    assign frameErr = !rxStopBit;
    assign parityErr = serialControl[UFS_SC_PAR_EN]
        && ((^{rxData, rxParityBit}) != serialControl[UFS_SC_PAR_ODD]);
    assign rxErr = frameErr || parityErr;
    // Bad characters are stored anyway with their error bits
    assign rxPush = rxCharDone && serialControl[UFS_SC_RE];
    assign rxEntry = {frameErr, parityErr, rxData};
    assign headErr = rxHead[UFS_RX_FER] || rxHead[UFS_RX_PER];

    // ****************************************
    // FIFOs
    // ****************************************
    ufs_fifo #(
        .WIDTH(8),
        .DEPTH(UFS_FIFO_DEPTH),
        .CNT_W(UFS_CNT_W)
    ) txFifo (
        .clk(clk),
        .rst(rst),
        .flush(standbyAny || fifoControl[UFS_FC_TX_FLUSH]),
        .push(txPush),
        .pushData(writedata[7:0]),
        .pop(txPop),
        .headData(txHead),
        .count(txCount),
        .full(txFull),
        .empty(txEmpty)
    );

    ufs_fifo #(
        .WIDTH(UFS_RXW),
        .DEPTH(UFS_FIFO_DEPTH),
        .CNT_W(UFS_CNT_W)
    ) rxFifo (
        .clk(clk),
        .rst(rst),
        .flush(standbyAny || fifoControl[UFS_FC_RX_FLUSH]),
        .push(rxPush),
        .pushData(rxEntry),
        .pop(rxPop),
        .headData(rxHead),
        .count(rxCount),
        .full(rxFull),
        .empty(rxEmpty)
    );

    // Occupancy one cycle ahead, as the FIFO will see it
    always_comb begin
        txCountAfter = txCount;
        if (txPush && !txFull && !txPop) begin
            txCountAfter = txCount + 5'h01;
        end else if (txPop && !(txPush && !txFull)) begin
            txCountAfter = txCount - 5'h01;
        end
        rxCountAfter = rxCount;
        if (rxPush && !rxFull && !rxPop) begin
            rxCountAfter = rxCount + 5'h01;
        end else if (rxPop && !(rxPush && !rxFull)) begin
            rxCountAfter = rxCount - 5'h01;
        end
    end

    assign txTrig = ufs_tx_trig({fifoControl[UFS_FC_TTRG_HI],
        fifoControl[UFS_FC_TTRG_LO]});
    assign rxTrig = ufs_rx_trig({fifoControl[UFS_FC_RTRG_HI],
        fifoControl[UFS_FC_RTRG_LO]});

    // Head staged into flops; shifter must leave a cycle between takes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txData <= 8'h00;
            txValid <= 1'b0;
        end else begin
            // Empty FIFO head is stale or unwritten storage; show zero instead
            txData <= txEmpty ? 8'h00 : txHead;
            txValid <= !txEmpty && !txPop;
        end
    end

    // ****************************************
    // Error count of stored characters
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            errCount <= 8'h00;
        end else if (standbyAny || fifoControl[UFS_FC_RX_FLUSH]) begin
            errCount <= 8'h00;
        end else begin
            // Push and pop may cancel each other in one cycle
            if ((rxPush && !rxFull && rxErr) && !(rxPop && headErr)) begin
                errCount <= errCount + 8'h01;
            end else if ((rxPop && headErr) && !(rxPush && !rxFull && rxErr)) begin
                errCount <= errCount - 8'h01;
            end
        end
    end

    // Per-character errors follow the head, not the newest arrival
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charFramingError <= 1'b0;
            charParityError <= 1'b0;
        end else if (standbyAny) begin
            charFramingError <= 1'b0;
            charParityError <= 1'b0;
        end else begin
            charFramingError <= !rxEmpty && rxHead[UFS_RX_FER];
            charParityError <= !rxEmpty && rxHead[UFS_RX_PER];
        end
    end

    // ****************************************
    // Sticky flags
    // ****************************************
    always_comb begin
        setEv = 8'h00;
        clrEv = 8'h00;
        setEv[UFS_BIT_ER] = rxPush && rxErr;
        setEv[UFS_BIT_TRANSMIT_END_FLAG] = (txLastBitDone && txEmpty)
            || !serialControl[UFS_SC_TE];
        setEv[UFS_BIT_TRANSMIT_FIFO_LOW_FLAG] = txPop && (txCountAfter < txTrig);
        setEv[UFS_BIT_BRK] = rxBreak;
        setEv[UFS_BIT_RDF] = rxPush && (rxCountAfter > rxTrig);
        setEv[UFS_BIT_DR] = rxDataReady;
        // Zero written over a bit that was seen as one; ones are ignored
        if (busWr && byteenable[0] && (address == UFS_OFS_STATUS)) begin
            clrEv = armed & ~writedata[7:0] & UFS_CLEARABLE;
        end
        clrEv[UFS_BIT_TRANSMIT_END_FLAG] = clrEv[UFS_BIT_TRANSMIT_END_FLAG] || txPush;
        clrEv[UFS_BIT_TRANSMIT_FIFO_LOW_FLAG] = clrEv[UFS_BIT_TRANSMIT_FIFO_LOW_FLAG]
            || (txPush && (txCountAfter > txTrig));
        clrEv[UFS_BIT_RDF] = clrEv[UFS_BIT_RDF]
            || (rxPop && (rxCountAfter < rxTrig));
        // Set beats clear in the same cycle
        next_flags = ((flags & ~clrEv) | setEv) & UFS_CLEARABLE;
    end

    // Receiver enable plays no part here, so flags survive it going low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= UFS_STATUS_RESET[7:0];
        end else if (standbyAny) begin
            flags <= UFS_STATUS_RESET[7:0];
        end else begin
            flags <= next_flags;
        end
    end

    // Read of the status word arms each of bits 7 to 4, 1 and 0 that showed one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 8'h00;
        end else if (standbyAny) begin
            armed <= 8'h00;
        end else if (busRd && (address == UFS_OFS_STATUS)) begin
            armed <= flags & UFS_CLEARABLE;
        end else begin
            armed <= armed & flags; // Drop arming once a flag is gone
        end
    end

    // Bits 3 and 2 come only from the head character, never from writes
    assign statusWord = {errCount, flags[7:4], charFramingError, charParityError,
        flags[1:0]};

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serialControl <= UFS_SERCTL_RESET;
        end else if (busWr && byteenable[0] && (address == UFS_OFS_SERCTL)) begin
            serialControl <= writedata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifoControl <= UFS_FIFOCTL_RESET;
        end else if (busWr && byteenable[0] && (address == UFS_OFS_FIFOCTL)) begin
            fifoControl <= writedata[7:0];
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Unmapped addresses read as zero and ignore writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (busRd) begin
            case (address)
                UFS_OFS_STATUS: readdata <= {16'h0000, statusWord};
                UFS_OFS_SERCTL: readdata <= {24'h000000, serialControl};
                UFS_OFS_FIFOCTL: readdata <= {24'h000000, fifoControl};
                UFS_OFS_RXDATA: readdata <= {24'h000000, rxHead[7:0]};
                UFS_OFS_COUNT: readdata <= {16'h0000, 3'h0, txCount,
                    3'h0, rxCount};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ### testbench/ufs_status_sva.sv
`timescale 1ns/10ps
// ****************************************
// Port checker for the status block
// ****************************************
module ufs_status_sva
    import ufs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic standby,
    input wire logic moduleStandby,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txTake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Request taken, and a read taken at one address
    sequence s_taken;
        (read || write) && waitrequest;
    endsequence
    sequence s_readAt(logic [7:0] a);
        read && waitrequest && address == a;
    endsequence

    property p_answerNext; s_taken |=> !waitrequest; endproperty
    a_answerNext: assert property (p_answerNext) else $error("no answer after request");
    property p_answerOne; !waitrequest |=> waitrequest; endproperty
    a_answerOne: assert property (p_answerOne) else $error("answer held too long");
    property p_noSpurious; !read && !write && waitrequest |=> waitrequest; endproperty
    a_noSpurious: assert property (p_noSpurious) else $error("answer without request");
    // Read data stands until the next read is taken
    property p_readHold; !(read && waitrequest) |=> $stable(readdata); endproperty
    a_readHold: assert property (p_readHold) else $error("read data moved");
    property p_upperZero; s_readAt(UFS_OFS_STATUS) |=> readdata[31:16] == 16'h0000; endproperty
    a_upperZero: assert property (p_upperZero) else $error("status wider than 16 bits");
    property p_standbyValue;
        standby && $past(standby) ##0 s_readAt(UFS_OFS_STATUS) |=> readdata[15:0] == 16'h0060;
    endproperty
    a_standbyValue: assert property (p_standbyValue) else $error("standby status");
    property p_unmappedZero; s_readAt(8'h18) |=> readdata == 32'h0000_0000; endproperty
    a_unmappedZero: assert property (p_unmappedZero) else $error("unmapped read");
    property p_takeDrops; txTake |=> !txValid; endproperty
    a_takeDrops: assert property (p_takeDrops) else $error("offer kept after take");
    // An offered byte waits unchanged for the shifter
    property p_offerHeld;
        txValid && !txTake && !standby && !moduleStandby |=> txValid && $stable(txData);
    endproperty
    a_offerHeld: assert property (p_offerHeld) else $error("offered byte disturbed");
endmodule

bind ufs_status ufs_status_sva chk (.clk, .rst, .address, .read, .write, .readdata,
    .waitrequest, .standby, .moduleStandby, .txData, .txValid, .txTake);

// ### testbench/ufs_line_model.sv
`timescale 1ns/10ps
// ****************************************
// Far-side serial shifter model
// ****************************************
module ufs_line_model #(
    parameter int BIT_CYCLES = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txTake,
    output logic txLastBitDone,
    output logic rxCharDone,
    output logic [7:0] rxData,
    output logic rxParityBit,
    output logic rxStopBit,
    output logic rxBreak,
    output logic rxDataReady
);
    logic hold;
    logic [7:0] lastByte;
    int nSent;
    int busy;

    initial begin
        {txTake, txLastBitDone, rxCharDone, rxBreak, rxDataReady} = 5'h00;
        {rxData, rxParityBit, rxStopBit} = 10'h000;
        hold = 1'b0;
    end

    // Takes one byte, then shifts it for BIT_CYCLES; the gap keeps takes apart
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            txTake <= 1'b0;
            txLastBitDone <= 1'b0;
            busy <= 0;
            nSent <= 0;
        end else begin
            txTake <= 1'b0;
            txLastBitDone <= 1'b0;
            if (busy > 0) begin
                busy <= busy - 1;
                txLastBitDone <= (busy == 1);
            end else if (txValid && !hold && !txTake) begin
                txTake <= 1'b1;
                lastByte <= txData;
                nSent <= nSent + 1;
                busy <= BIT_CYCLES;
            end
        end
    end

    // One received character; only the first stop bit is handed on
    task automatic sendChar(input logic [7:0] d, input logic p, input logic s);
        rxData <= d;
        rxParityBit <= p;
        rxStopBit <= s;
        rxCharDone <= 1'b1;
        @(posedge clk);
        rxCharDone <= 1'b0;
        rxData <= ~d; // Stale data must not be relied on
        rxParityBit <= ~p;
        rxStopBit <= ~s;
        @(posedge clk);
    endtask

    // Break and data-ready events together
    task automatic pulseFlags();
        rxBreak <= 1'b1;
        rxDataReady <= 1'b1;
        @(posedge clk);
        rxBreak <= 1'b0;
        rxDataReady <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// ### testbench/ufs_status_tb.sv
`timescale 1ns/10ps
module ufs_status_tb
    import ufs_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] e;} ufs_row_t;
    logic clk, rst, read, write, waitrequest, standby, moduleStandby;
    logic txValid, txTake, txLastBitDone, rxCharDone, rxParityBit, rxStopBit, rxBreak;
    logic rxDataReady;
    logic [7:0] address, rxData, txData;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata;
    int checks = 0;
    int n_mismatch = 0;
    int cycles = 0;
    ufs_row_t rows[5] = '{'{UFS_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0060},
        '{UFS_OFS_SERCTL, 32'hFFFF_FFFF, 32'h0}, '{UFS_OFS_FIFOCTL, 32'hFFFF_FFFF, 32'h0},
        '{UFS_OFS_COUNT, 32'hFFFF_FFFF, 32'h0}, '{8'h18, 32'hFFFF_FFFF, 32'h0}};

    ufs_status dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .standby(standby), .moduleStandby(moduleStandby),
        .rxCharDone(rxCharDone), .rxData(rxData), .rxParityBit(rxParityBit),
        .rxStopBit(rxStopBit), .rxBreak(rxBreak), .rxDataReady(rxDataReady),
        .txData(txData), .txValid(txValid), .txTake(txTake), .txLastBitDone(txLastBitDone));
    ufs_line_model partner (.clk(clk), .rst(rst), .txData(txData), .txValid(txValid),
        .txTake(txTake), .txLastBitDone(txLastBitDone), .rxCharDone(rxCharDone),
        .rxData(rxData), .rxParityBit(rxParityBit), .rxStopBit(rxStopBit),
        .rxBreak(rxBreak), .rxDataReady(rxDataReady));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Ceiling well above the longest drain of a full transmit FIFO
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until waitrequest is seen low, then an idle cycle
    task automatic busCycle(input logic rd, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        busCycle(1'b0, a, d, q);
    endtask

    task automatic expectReg(input string name, input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        logic [31:0] q;
        busCycle(1'b1, a, 32'h0, q);
        check(name, q & m, e);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, read, write, standby, moduleStandby} = 5'h10;
        address = 8'h00;
        byteenable = 4'hF;
        writedata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) expectReg("reset row", rows[i].a, rows[i].m, rows[i].e);
        wr(UFS_OFS_STATUS, 32'h0000_FFFF);
        expectReg("ones write", UFS_OFS_STATUS, 32'hFFFF, 32'h0060);
        // Standby drops the arming left by the reads above
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        @(posedge clk);
        wr(UFS_OFS_SERCTL, 32'h32);
        wr(UFS_OFS_STATUS, 32'h0);
        expectReg("unarmed clear", UFS_OFS_STATUS, 32'hFFFF, 32'h0060);
        wr(UFS_OFS_STATUS, 32'h0);
        expectReg("armed clear", UFS_OFS_STATUS, 32'hFFFF, 32'h0000);
        // Good, parity-bad and framing-bad characters under even parity
        partner.sendChar(8'h03, 1'b0, 1'b1);
        partner.sendChar(8'h01, 1'b0, 1'b1);
        partner.sendChar(8'h00, 1'b0, 1'b0);
        expectReg("rx errors", UFS_OFS_STATUS, 32'hFFFF, 32'h0282);
        wr(UFS_OFS_SERCTL, 32'h22);
        expectReg("rx off", UFS_OFS_STATUS, 32'hFFFF, 32'h0282);
        expectReg("pop good", UFS_OFS_RXDATA, 32'hFF, 32'h03);
        expectReg("head parity", UFS_OFS_STATUS, 32'hFFFF, 32'h0286);
        expectReg("pop bad", UFS_OFS_RXDATA, 32'hFF, 32'h01);
        expectReg("head framing", UFS_OFS_STATUS, 32'hFFFF, 32'h018A);
        wr(UFS_OFS_STATUS, 32'h0);
        expectReg("read only", UFS_OFS_STATUS, 32'hFFFF, 32'h0108);
        // Odd parity: one good, one bad
        wr(UFS_OFS_SERCTL, 32'h33);
        partner.sendChar(8'h01, 1'b0, 1'b1);
        partner.sendChar(8'h01, 1'b1, 1'b1);
        expectReg("odd parity", UFS_OFS_STATUS, 32'hFFFF, 32'h028A);
        // Shifter stalled while the FIFO is overfilled by one
        partner.hold <= 1'b1;
        for (int i = 0; i < 17; i++) wr(UFS_OFS_TXDATA, 32'(8'h40 + i));
        expectReg("tx count", UFS_OFS_COUNT, 32'h1F00, 32'h1000);
        expectReg("tx filled", UFS_OFS_STATUS, 32'h60, 32'h00);
        partner.hold <= 1'b0;
        while (partner.nSent < 16) @(posedge clk);
        repeat (10) @(posedge clk);
        check("last byte", {24'h0, partner.lastByte}, 32'h4F);
        expectReg("tx drained", UFS_OFS_STATUS, 32'h60, 32'h60);
        wr(UFS_OFS_TXDATA, 32'h5A);
        expectReg("tx restart", UFS_OFS_STATUS, 32'h40, 32'h00);
        // Break and data ready, then both standby inputs
        for (int k = 0; k < 2; k++) begin
            partner.pulseFlags();
            expectReg("break", UFS_OFS_STATUS, 32'h11, 32'h11);
            if (k == 0) standby <= 1'b1;
            else moduleStandby <= 1'b1;
            @(posedge clk);
            expectReg("standby", UFS_OFS_STATUS, 32'hFFFF, 32'h0060);
            standby <= 1'b0;
            moduleStandby <= 1'b0;
            @(posedge clk);
            expectReg("flushed", UFS_OFS_COUNT, 32'h1F1F, 32'h0);
        end
        // Smallest transmit trigger: two queued bytes already clear transmit-low
        wr(UFS_OFS_FIFOCTL, 32'h30);
        partner.hold <= 1'b1;
        wr(UFS_OFS_TXDATA, 32'h61);
        wr(UFS_OFS_TXDATA, 32'h62);
        expectReg("tx trigger", UFS_OFS_STATUS, 32'h60, 32'h00);
        results();
    end
endmodule
